// >>> src/cfpc_pkg.sv
// Shared constants and types for the flags and program counter core.
package cfpc_pkg;

  // ----------------------------------------------------------------
  // Register offsets in the system register area
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LOOKUP = 8'h82; // Lookup result register.
  localparam logic [7:0] ADDR_PTR_LO = 8'h83; // Pointer, location byte.
  localparam logic [7:0] ADDR_PTR_HI = 8'h84; // Pointer, bank byte.
  localparam logic [7:0] ADDR_FLAGS = 8'h86; // Program status flags.
  localparam logic [7:0] IMM_LO = 8'h80; // First immediate-writable register.
  localparam logic [7:0] IMM_HI = 8'h87; // Last immediate-writable register.

  // ----------------------------------------------------------------
  // Field positions of the program status flags
  // ----------------------------------------------------------------
  localparam int FLG_CAUSE_HI = 7; // Reset cause, upper bit.
  localparam int FLG_CAUSE_LO = 6; // Reset cause, lower bit.
  localparam int FLG_V36 = 5; // High threshold voltage flag.
  localparam int FLG_V24 = 4; // Middle threshold voltage flag.
  localparam int FLG_C = 2; // Carry flag.
  localparam int FLG_DC = 1; // Half carry flag.
  localparam int FLG_Z = 0; // Zero flag.

  // ----------------------------------------------------------------
  // Reset cause codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CAUSE_WDT = 2'h0; // Watchdog timeout.
  localparam logic [1:0] CAUSE_RSVD = 2'h1; // Reserved code.
  localparam logic [1:0] CAUSE_LVD = 2'h2; // Low-voltage reset.
  localparam logic [1:0] CAUSE_EXT = 2'h3; // External reset pin.

  // ----------------------------------------------------------------
  // Counter geometry and data constants
  // ----------------------------------------------------------------
  localparam int PC_W = 11; // Program counter width.
  localparam int PCH_W = 3; // High byte width.
  localparam logic [10:0] PC_RESET = 11'h000; // Counter after reset.
  localparam logic [7:0] BYTE_FF = 8'hFF; // Increment wrap source.
  localparam logic [7:0] BYTE_01 = 8'h01; // Decrement wrap source.
  localparam logic [3:0] NIB_ONE = 4'h1; // Single step.
  localparam logic [3:0] NIB_TWO = 4'h2; // Skip step.

  // One executed instruction as seen by this core.
  typedef enum logic [4:0] {
    OP_STEP, OP_ADD, OP_ADC, OP_SUB, OP_RLC, OP_RRC, OP_AND, OP_OR, OP_XOR,
    OP_CMPS, OP_INCREMENT_ACC_SKIP, OP_DECREMENT_ACC_SKIP, OP_SKIP_IF_BIT_CLEAR, OP_SKIP_IF_BIT_SET, OP_JMP, OP_ADDPCL,
    OP_ADCPCL, OP_SUBPCL, OP_MOVPCL, OP_TABLE_READ_OP
  } cfpc_op_t;

endpackage

// >>> src/cfpc_alu.sv
// Arithmetic unit producing a result byte and carry, half carry, zero.
`timescale 1ns/100ps
module cfpc_alu (
  input wire cfpc_pkg::cfpc_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  output logic [7:0] res,
  output logic c,
  output logic dc,
  output logic z
);
  import cfpc_pkg::*;

  // ----------------------------------------------------------------
  // Result and flag generation
  // ----------------------------------------------------------------
  // Add forms share one adder; the counter-byte forms reuse it so a
  // computed jump sees exactly the carry an ordinary add would give.
  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    sum = '0;
    nib = '0;
    res = a;
    c = 1'b0;
    dc = 1'b0;
    unique case (op)
      OP_ADD, OP_ADC, OP_ADDPCL, OP_ADCPCL: begin
        sum = {1'b0, a} + {1'b0, b} + {8'h00, cin & (op == OP_ADC || op == OP_ADCPCL)};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin & (op == OP_ADC || op == OP_ADCPCL)};
        res = sum[7:0];
        c = sum[8];
        dc = nib[4];
      end
      OP_SUB, OP_SUBPCL, OP_CMPS: begin
        // Carry means no borrow, so a compare gives carry for a >= b.
        res = a - b;
        c = (a >= b);
        dc = (a[3:0] >= b[3:0]);
      end
      OP_RLC: begin
        res = {a[6:0], cin};
        c = a[7];
      end
      OP_RRC: begin
        res = {cin, a[7:1]};
        c = a[0];
      end
      OP_AND: res = a & b;
      OP_OR: res = a | b;
      OP_XOR: res = a ^ b;
      OP_INCREMENT_ACC_SKIP: res = b + 8'h01;
      OP_DECREMENT_ACC_SKIP: res = b - 8'h01;
      default: res = a;
    endcase
    z = (res == 8'h00);
  end

endmodule

// >>> src/cfpc_skip.sv
// Condition evaluation for the one-address skipping instructions.
`timescale 1ns/100ps
module cfpc_skip (
  input wire cfpc_pkg::cfpc_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [2:0] bit_sel,
  output logic skip
);
  import cfpc_pkg::*;

  // ----------------------------------------------------------------
  // Skip decision
  // ----------------------------------------------------------------
  // Bank-0 bit tests differ only in how the operand was fetched, so
  // they arrive here as the plain bit-test codes.
  always_comb begin
    unique case (op)
      OP_CMPS: skip = (a == b);
      OP_INCREMENT_ACC_SKIP: skip = (b == BYTE_FF);
      OP_DECREMENT_ACC_SKIP: skip = (b == BYTE_01);
      OP_SKIP_IF_BIT_CLEAR: skip = ~b[bit_sel];
      OP_SKIP_IF_BIT_SET: skip = b[bit_sel];
      default: skip = 1'b0;
    endcase
  end

endmodule

// >>> src/cfpc_core.sv
// Program status flags, program counter and pointer registers of the core.
//
// Overview of operation
// - Status register holds cause, voltage, carry flags.
// - Cause codes: watchdog, reserved, low-voltage, external.
// - High threshold flag follows supply when chosen.
// - Middle threshold flag follows supply when chosen.
// - Carry set on carry, no borrow, compare.
// - Half carry set on nibble carry, no borrow.
// - Zero flag set when result is zero.
// - Eleven-bit counter, split high and low, reset zero.
// - Counter advances one per executed instruction.
// - Jump loads whole destination address.
// - True skip condition advances counter by two.
// - Compare skips when accumulator equals operand.
// - Increment skips when value wraps to zero.
// - Decrement skips when one becomes zero.
// - Bit test skips on the checked value.
// - Low byte add overflow increments high byte.
// - Low byte borrow leaves high byte alone.
// - Move to low byte jumps within page.
// - Two pointer registers form indirect address.
// - Table read splits word into lookup, accumulator.
// - Immediate writes only reach working registers.
`timescale 1ns/100ps
module cfpc_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] reset_cause,
  input wire logic supply_le_high,
  input wire logic supply_le_mid,
  input wire logic high_detect_option,
  input wire logic mid_detect_option,
  input wire logic [7:0] reg_addr,
  input wire logic reg_we,
  input wire logic reg_imm,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_re,
  input wire logic op_valid,
  input wire cfpc_pkg::cfpc_op_t op_code,
  input wire logic [7:0] op_acc,
  input wire logic [7:0] op_operand,
  input wire logic [2:0] op_bit,
  input wire logic [10:0] op_target,
  input wire logic [15:0] rom_data,
  output logic [10:0] program_counter,
  output logic [15:0] indirect_operand,
  output logic [7:0] result_q,
  output logic acc_we_q,
  output logic [7:0] reg_rdata_q,
  output logic imm_err_q
);
  import cfpc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // All flip-flops of the block live in this one record.
  typedef struct packed {
    logic [PCH_W-1:0] counter_high_byte; // Counter high byte.
    logic [7:0] counter_low_byte; // Counter low byte.
    logic [7:0] lookup; // Lookup result register.
    logic [7:0] ptr_lo; // Pointer location byte.
    logic [7:0] ptr_hi; // Pointer bank byte.
    logic [1:0] cause; // Reset cause field.
    logic v36; // High threshold voltage flag.
    logic v24; // Middle threshold voltage flag.
    logic c; // Carry flag.
    logic dc; // Half carry flag.
    logic z; // Zero flag.
    logic [7:0] result; // Value for the accumulator.
    logic acc_we; // Accumulator write strobe.
    logic [7:0] rdata; // Register read data.
    logic imm_err; // Refused immediate write.
  } cfpc_state_t;

  cfpc_state_t s_q; // Registered state.
  cfpc_state_t s_d; // Next state.
  logic [7:0] alu_a; // First ALU operand.
  logic [7:0] alu_res; // ALU result.
  logic alu_c; // ALU carry out.
  logic alu_dc; // ALU half carry out.
  logic alu_z; // ALU zero out.
  logic skip; // Skip condition true.

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Advances the whole counter; wrap past the top is the natural one.
  function automatic logic [10:0] pc_add(input logic [10:0] pc, input logic [3:0] k);
    pc_add = pc + {7'h00, k};
  endfunction

  // Assembles the status byte as software reads it; bit 3 reads zero.
  function automatic logic [7:0] flags_byte(input cfpc_state_t s);
    flags_byte = {s.cause, s.v36, s.v24, 1'b0, s.c, s.dc, s.z};
  endfunction

  // Counter-byte add and subtract operations take the low byte as their first operand.
  assign alu_a = (op_code == OP_ADDPCL || op_code == OP_ADCPCL ||
                  op_code == OP_SUBPCL) ? s_q.counter_low_byte : op_acc;

  cfpc_alu u_alu (
    .op(op_code),
    .a(alu_a),
    .b(op_operand),
    .cin(s_q.c),
    .res(alu_res),
    .c(alu_c),
    .dc(alu_dc),
    .z(alu_z)
  );

  cfpc_skip u_skip (
    .op(op_code),
    .a(op_acc),
    .b(op_operand),
    .bit_sel(op_bit),
    .skip(skip)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Software writes are applied first and the executing instruction
  // afterwards, so a flag set by hardware in the same cycle as a
  // software write wins over it.
  always_comb begin
    logic [10:0] pc_now;
    logic [10:0] pc_nxt;
    pc_now = {s_q.counter_high_byte, s_q.counter_low_byte};
    pc_nxt = pc_now;
    s_d = s_q;
    s_d.acc_we = 1'b0;
    s_d.imm_err = 1'b0;
    // Voltage flags are read-only and only valid with their option.
    s_d.v36 = supply_le_high & high_detect_option;
    s_d.v24 = supply_le_mid & mid_detect_option;
    // Read data is captured on the strobe and then held.
    if (reg_re) begin
      unique case (reg_addr)
        ADDR_LOOKUP: s_d.rdata = s_q.lookup;
        ADDR_PTR_LO: s_d.rdata = s_q.ptr_lo;
        ADDR_PTR_HI: s_d.rdata = s_q.ptr_hi;
        ADDR_FLAGS: s_d.rdata = flags_byte(s_q);
        default: s_d.rdata = 8'h00;
      endcase
    end
    if (reg_we) begin
      if (reg_imm && (reg_addr < IMM_LO || reg_addr > IMM_HI)) begin
        // Immediate data may only land in the working registers.
        s_d.imm_err = 1'b1;
      end else begin
        unique case (reg_addr)
          ADDR_LOOKUP: s_d.lookup = reg_wdata;
          ADDR_PTR_LO: s_d.ptr_lo = reg_wdata;
          ADDR_PTR_HI: s_d.ptr_hi = reg_wdata;
          ADDR_FLAGS: begin
            s_d.cause = reg_wdata[FLG_CAUSE_HI:FLG_CAUSE_LO];
            s_d.c = reg_wdata[FLG_C];
            s_d.dc = reg_wdata[FLG_DC];
            s_d.z = reg_wdata[FLG_Z];
          end
          default: s_d.imm_err = 1'b0;
        endcase
      end
    end
    if (op_valid) begin
      pc_nxt = pc_add(pc_now, NIB_ONE);
      unique case (op_code)
        OP_ADD, OP_ADC, OP_SUB: begin
          s_d.c = alu_c;
          s_d.dc = alu_dc;
          s_d.z = alu_z;
          s_d.result = alu_res;
          s_d.acc_we = 1'b1;
        end
        OP_RLC, OP_RRC: begin
          s_d.c = alu_c;
          s_d.result = alu_res;
          s_d.acc_we = 1'b1;
        end
        OP_AND, OP_OR, OP_XOR: begin
          s_d.z = alu_z;
          s_d.result = alu_res;
          s_d.acc_we = 1'b1;
        end
        OP_CMPS, OP_SKIP_IF_BIT_CLEAR, OP_SKIP_IF_BIT_SET, OP_INCREMENT_ACC_SKIP, OP_DECREMENT_ACC_SKIP: begin
          if (op_code == OP_CMPS) begin
            s_d.c = alu_c;
            s_d.z = alu_z;
          end
          if (op_code == OP_INCREMENT_ACC_SKIP || op_code == OP_DECREMENT_ACC_SKIP) begin
            s_d.result = alu_res;
            s_d.acc_we = 1'b1;
          end
          if (skip) begin
            pc_nxt = pc_add(pc_now, NIB_TWO);
          end
        end
        OP_JMP: pc_nxt = op_target;
        OP_ADDPCL, OP_ADCPCL: begin
          s_d.c = alu_c;
          s_d.dc = alu_dc;
          s_d.z = alu_z;
          // The low-byte carry ripples into the page byte.
          pc_nxt = {s_q.counter_high_byte + {2'b00, alu_c}, alu_res};
        end
        OP_SUBPCL: begin
          s_d.c = alu_c;
          s_d.dc = alu_dc;
          s_d.z = alu_z;
          // A borrow never reaches the page byte.
          pc_nxt = {s_q.counter_high_byte, alu_res};
        end
        OP_MOVPCL: pc_nxt = {s_q.counter_high_byte, op_operand};
        OP_TABLE_READ_OP: begin
          // The pointer pair addresses the word presented on rom_data.
          s_d.lookup = rom_data[15:8];
          s_d.result = rom_data[7:0];
          s_d.acc_we = 1'b1;
        end
        default: pc_nxt = pc_add(pc_now, NIB_ONE);
      endcase
    end
    s_d.counter_high_byte = pc_nxt[10:8];
    s_d.counter_low_byte = pc_nxt[7:0];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // The cause field is caught from the reset sequencer while reset is
  // held; pointers are cleared only so that simulation starts clean.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.cause <= reset_cause;
    end else begin
      s_q <= s_d;
    end
  end

  assign program_counter = {s_q.counter_high_byte, s_q.counter_low_byte};
  assign indirect_operand = {s_q.ptr_hi, s_q.ptr_lo};
  assign result_q = s_q.result;
  assign acc_we_q = s_q.acc_we;
  assign reg_rdata_q = s_q.rdata;
  assign imm_err_q = s_q.imm_err;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // The reset checks lift the default disable, or they could never start.
  AST_PC_RESET: assert property (@(posedge clk_sys) disable iff (1'b0)
      rst |=> program_counter == PC_RESET)
    else $error("counter not zero after reset");
  AST_CAUSE: assert property (@(posedge clk_sys) disable iff (1'b0)
      rst |=> s_q.cause == $past(reset_cause))
    else $error("reset cause not captured");
  AST_STEP: assert property (op_valid && op_code == OP_STEP
      |=> program_counter == $past(program_counter) + 11'h001)
    else $error("counter did not step by one");
  AST_JUMP: assert property (op_valid && op_code == OP_JMP && !reg_we
      |=> program_counter == $past(op_target))
    else $error("jump target not loaded");
  AST_SKIP: assert property (op_valid && skip
      |=> program_counter == $past(program_counter) + 11'h002)
    else $error("true skip did not advance by two");
  AST_PCL_CARRY: assert property (op_valid && op_code == OP_ADDPCL && alu_c
      |=> s_q.counter_high_byte == $past(s_q.counter_high_byte) + 3'h1)
    else $error("page byte missed low byte carry");
  AST_PCL_BORROW: assert property (op_valid && op_code == OP_SUBPCL
      |=> $stable(s_q.counter_high_byte))
    else $error("page byte moved on borrow");
  AST_MOVPCL: assert property (op_valid && op_code == OP_MOVPCL
      |=> s_q.counter_low_byte == $past(op_operand) && $stable(s_q.counter_high_byte))
    else $error("low byte move left page");
  AST_VOLT: assert property (1'b1
      |=> s_q.v36 == $past(supply_le_high & high_detect_option)
      && s_q.v24 == $past(supply_le_mid & mid_detect_option))
    else $error("voltage flag wrong");
  AST_TABLE_READ_OP: assert property (op_valid && op_code == OP_TABLE_READ_OP
      |=> s_q.lookup == $past(rom_data[15:8]) && result_q == $past(rom_data[7:0])
      ##1 !acc_we_q || $past(op_valid))
    else $error("table read split wrong");
  AST_ZERO: assert property (op_valid && op_code == OP_ADD
      |=> s_q.z == (result_q == 8'h00) && s_q.c == $past(alu_c))
    else $error("add flags wrong");
  AST_IMM: assert property (reg_we && reg_imm && reg_addr > IMM_HI
      |=> imm_err_q ##1 !imm_err_q || $past(reg_we))
    else $error("immediate write outside range accepted");
  AST_ROT_CARRY: assert property (op_valid && (op_code == OP_RLC || op_code == OP_RRC)
      |=> s_q.c == $past(op_code == OP_RLC ? op_acc[7] : op_acc[0]))
    else $error("rotate carry wrong");
  AST_IMM_LOW: assert property (reg_we && reg_imm && reg_addr < IMM_LO |=> imm_err_q)
    else $error("immediate write below range accepted");

  COV_SKIP: cover property (op_valid && op_code == OP_INCREMENT_ACC_SKIP && skip);
  COV_PCL_CARRY: cover property (op_valid && op_code == OP_ADDPCL && alu_c);
  COV_ADCPCL: cover property (op_valid && op_code == OP_ADCPCL && alu_c);
  COV_TABLE_READ_OP: cover property (op_valid && op_code == OP_TABLE_READ_OP);

endmodule

// >>> dv/cfpc_core_bench.sv
// Self-checking random bench for the flags and program counter core.
`timescale 1ns/100ps
module cfpc_core_bench;
  import cfpc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, design outputs and bookkeeping
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0; // 100 MHz system clock.
  logic rst = 1'b1; // Held high for the first five cycles.
  logic [1:0] reset_cause = 2'h3; // Cause code shown while in reset.
  logic supply_le_high = 1'b0;
  logic supply_le_mid = 1'b0;
  logic high_detect_option = 1'b0;
  logic mid_detect_option = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_we = 1'b0;
  logic reg_imm = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_re = 1'b0;
  logic op_valid = 1'b0;
  cfpc_op_t op_code = OP_STEP;
  logic [7:0] op_acc = 8'h00;
  logic [7:0] op_operand = 8'h00;
  logic [2:0] op_bit = 3'h0;
  logic [10:0] op_target = 11'h000;
  logic [15:0] rom_data = 16'h0000;
  logic [10:0] program_counter;
  logic [15:0] indirect_operand;
  logic [7:0] result_q;
  logic acc_we_q;
  logic [7:0] reg_rdata_q;
  logic imm_err_q;
  int failures = 0; // Mismatches seen.
  int n_checks = 0; // Comparisons made.
  integer seed = 32'h9614_ab9f; // Fixed so every run repeats.
  logic [7:0] a, b, d, e, rd, res;
  logic we, err, sk;
  logic [10:0] t, pc0;
  logic [13:0] ex;
  logic [15:0] w;
  int k;
  cfpc_op_t alu_ops [6] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_CMPS};
  cfpc_op_t skp_ops [4] = '{OP_INCREMENT_ACC_SKIP, OP_DECREMENT_ACC_SKIP, OP_SKIP_IF_BIT_CLEAR, OP_SKIP_IF_BIT_SET};
  cfpc_op_t pcl_ops [4] = '{OP_ADDPCL, OP_SUBPCL, OP_MOVPCL, OP_ADCPCL};
  cfpc_op_t cin_ops [3] = '{OP_ADC, OP_RLC, OP_RRC};

  // Free-running clock, inverted every half period.
  always #5 clk_sys = ~clk_sys;

  cfpc_core dut (
    .clk_sys(clk_sys), .rst(rst), .reset_cause(reset_cause),
    .supply_le_high(supply_le_high), .supply_le_mid(supply_le_mid),
    .high_detect_option(high_detect_option), .mid_detect_option(mid_detect_option),
    .reg_addr(reg_addr), .reg_we(reg_we), .reg_imm(reg_imm), .reg_wdata(reg_wdata),
    .reg_re(reg_re), .op_valid(op_valid), .op_code(op_code), .op_acc(op_acc),
    .op_operand(op_operand), .op_bit(op_bit), .op_target(op_target),
    .rom_data(rom_data), .program_counter(program_counter),
    .indirect_operand(indirect_operand), .result_q(result_q), .acc_we_q(acc_we_q),
    .reg_rdata_q(reg_rdata_q), .imm_err_q(imm_err_q)
  );

  // ----------------------------------------------------------------
  // Bus tasks, expectation and comparison
  // ----------------------------------------------------------------
  // All tasks start and end on a falling edge, so strobes never toggle twice in one step.
  task automatic check_value(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One write; the refusal pulse is only up in the cycle after the taking edge.
  task automatic reg_wr(input logic [7:0] ad, input logic [7:0] dt, input logic imm);
    reg_addr = ad;
    reg_wdata = dt;
    reg_imm = imm;
    reg_we = 1'b1;
    @(negedge clk_sys);
    reg_we = 1'b0;
    err = imm_err_q;
    @(negedge clk_sys);
  endtask

  // One read; data is held after the answer, so rd is taken one edge later.
  task automatic reg_rd(input logic [7:0] ad);
    reg_addr = ad;
    reg_re = 1'b1;
    @(negedge clk_sys);
    reg_re = 1'b0;
    rd = reg_rdata_q;
    @(negedge clk_sys);
  endtask

  // One instruction; the accumulator write pulse is caught in its only cycle.
  task automatic do_op(input cfpc_op_t op, input logic [7:0] x, input logic [7:0] y,
                       input logic [2:0] bs, input logic [10:0] tg);
    op_code = op;
    op_acc = x;
    op_operand = y;
    op_bit = bs;
    op_target = tg;
    op_valid = 1'b1;
    @(negedge clk_sys);
    op_valid = 1'b0;
    res = result_q;
    we = acc_we_q;
    @(negedge clk_sys);
  endtask

  // Expected {result, carry, half carry, zero, mask of flags the op defines}.
  function automatic logic [13:0] alu_exp(input cfpc_op_t op, input logic [7:0] x,
                                          input logic [7:0] y);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] r;
    logic c, h;
    logic [2:0] m;
    s = {1'b0, x} + {1'b0, y};
    n = {1'b0, x[3:0]} + {1'b0, y[3:0]};
    r = s[7:0];
    c = s[8];
    h = n[4];
    m = 3'h7;
    case (op)
      OP_SUB, OP_CMPS: begin
        r = x - y;
        c = (x >= y);
        h = (x[3:0] >= y[3:0]);
        m = (op == OP_CMPS) ? 3'h5 : 3'h7;
      end
      OP_AND: begin
        r = x & y;
        m = 3'h1;
      end
      OP_OR: begin
        r = x | y;
        m = 3'h1;
      end
      OP_XOR: begin
        r = x ^ y;
        m = 3'h1;
      end
      default: begin
      end
    endcase
    return {r, c, h, r == 8'h00, m};
  endfunction

  // Expected {carry, result} of the forms that take the stored carry in.
  function automatic logic [8:0] cin_exp(input int k, input logic [7:0] x,
                                         input logic [7:0] y, input logic ci);
    if (k == 0) return {1'b0, x} + {1'b0, y} + {8'h00, ci};
    if (k == 1) return {x[7], x[6:0], ci};
    return {x[0], ci, x[7:1]};
  endfunction

  // Closing task shared by the main sequence and the watchdog.
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The whole run is about 880 cycles; this leaves ample margin.
  initial begin
    #100us;
    failures++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    // Every cause code is kept, the rest of the flags and the counter clear.
    // The first pass is the power-up reset itself.
    for (int i = 0; i < 4; i++) begin
      rst = 1'b1;
      reset_cause = i[1:0];
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      check_value({5'h00, program_counter}, 16'h0000);
      reg_rd(ADDR_FLAGS);
      check_value({8'h00, rd}, {8'h00, i[1:0], 6'h00});
    end
    $display("[TEST] reset done");
    // Voltage flags follow the comparators while their option is chosen.
    high_detect_option = 1'b1;
    mid_detect_option = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {supply_le_high, supply_le_mid} = i[1:0];
      @(negedge clk_sys);
      reg_rd(ADDR_FLAGS);
      check_value({14'h0000, rd[5:4]}, {14'h0000, i[1:0]});
    end
    {supply_le_high, supply_le_mid} = 2'h0;
    // Only cause and arithmetic flags take a write; bits 5 to 3 stay low.
    reg_wr(ADDR_FLAGS, 8'hff, 1'b0);
    reg_rd(ADDR_FLAGS);
    check_value({8'h00, rd}, 16'h00c7);
    $display("[TEST] flags done");
    // Pointer pair and lookup byte, some by immediate write.
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      e = 8'($random(seed));
      reg_wr(ADDR_PTR_LO, d, i[0]);
      check_value({15'h0000, err}, 16'h0000);
      reg_wr(ADDR_PTR_HI, e, 1'b0);
      reg_wr(ADDR_LOOKUP, d ^ e, i[1]);
      check_value(indirect_operand, {e, d});
      reg_rd(ADDR_LOOKUP);
      check_value({8'h00, rd}, {8'h00, d ^ e});
    end
    reg_rd(8'h85);
    check_value({8'h00, rd}, 16'h0000);
    reg_wr(IMM_HI, 8'h5a, 1'b1);
    check_value({15'h0000, err}, 16'h0000);
    reg_wr(8'h88, 8'h5a, 1'b1);
    check_value({15'h0000, err}, 16'h0001);
    reg_wr(8'h12, 8'h5a, 1'b1);
    check_value({15'h0000, err}, 16'h0001);
    reg_wr(ADDR_PTR_LO, 8'h3c, 1'b0);
    $display("[TEST] registers done");
    // Random arithmetic and logic with carry and equality corners.
    for (int i = 0; i < 60; i++) begin
      k = {$random(seed)} % 6;
      a = (i == 0) ? 8'hff : 8'($random(seed));
      b = (i == 0) ? 8'h01 : ((i % 4 == 1) ? a : 8'($random(seed)));
      pc0 = program_counter;
      ex = alu_exp(alu_ops[k], a, b);
      sk = (alu_ops[k] == OP_CMPS) && (a == b);
      do_op(alu_ops[k], a, b, 3'h0, 11'h000);
      if (alu_ops[k] != OP_CMPS) check_value({7'h00, we, res}, {8'h01, ex[13:6]});
      check_value({5'h00, program_counter}, {5'h00, pc0 + (sk ? 11'h002 : 11'h001)});
      reg_rd(ADDR_FLAGS);
      check_value({13'h0000, rd[2:0] & ex[2:0]}, {13'h0000, ex[5:3] & ex[2:0]});
    end
    // Stored carry feeds add-with-carry and both rotations.
    for (int i = 0; i < 24; i++) begin
      a = 8'($random(seed));
      b = 8'($random(seed));
      sk = i[3];
      reg_wr(ADDR_FLAGS, {5'h00, sk, 2'h0}, 1'b0);
      w = {7'h00, cin_exp(i % 3, a, b, sk)};
      do_op(cin_ops[i % 3], a, b, 3'h0, 11'h000);
      check_value({8'h00, res}, {8'h00, w[7:0]});
      reg_rd(ADDR_FLAGS);
      check_value({15'h0000, rd[2]}, {15'h0000, w[8]});
    end
    // Service-routine discipline: save the flags, clobber them, put them back.
    reg_wr(ADDR_FLAGS, 8'h45, 1'b0);
    reg_rd(ADDR_FLAGS);
    e = rd;
    do_op(OP_SUB, 8'h00, 8'h01, 3'h0, 11'h000);
    reg_rd(ADDR_FLAGS);
    check_value({8'h00, rd}, 16'h0040);
    reg_wr(ADDR_FLAGS, e, 1'b0);
    reg_rd(ADDR_FLAGS);
    check_value({8'h00, rd}, 16'h0045);
    $display("[TEST] alu done");
    // Skip instructions with wrap values forced in early.
    for (int i = 0; i < 40; i++) begin
      k = (i < 8) ? i % 2 : {$random(seed)} % 4;
      b = (i < 8) ? ((k == 0) ? 8'hff : 8'h01) : 8'($random(seed));
      a = 8'($random(seed));
      t = 11'($random(seed));
      pc0 = program_counter;
      case (k)
        0: sk = (b == 8'hff);
        1: sk = (b == 8'h01);
        2: sk = ~b[t[2:0]];
        default: sk = b[t[2:0]];
      endcase
      do_op(skp_ops[k], a, b, t[2:0], 11'h000);
      check_value({5'h00, program_counter}, {5'h00, pc0 + (sk ? 11'h002 : 11'h001)});
      if (k < 2) check_value({8'h00, res}, {8'h00, (k == 0) ? b + 8'h01 : b - 8'h01});
    end
    $display("[TEST] skip done");
    // Jumps, then computed jumps through the low counter byte.
    for (int i = 0; i < 32; i++) begin
      t = (i == 0) ? 11'h323 : 11'($random(seed));
      a = (i == 0) ? 8'h28 : 8'($random(seed));
      reg_wr(ADDR_FLAGS, {5'h00, t[0], 2'h0}, 1'b0);
      do_op(OP_JMP, 8'h00, 8'h00, 3'h0, t);
      check_value({5'h00, program_counter}, {5'h00, t});
      k = i % 4;
      // The page byte is three bits wide, so a carry out of page 7 wraps to 0.
      w = {5'h00, t[10:8], t[7:0] - a};
      if (k == 0 || k == 3) w = {5'h00, t + 11'(a) + ((k == 3) ? 11'(t[0]) : 11'h000)};
      if (k == 2) w = {5'h00, t[10:8], a};
      do_op(pcl_ops[k], a, a, 3'h0, 11'h000);
      check_value({5'h00, program_counter}, w);
      do_op(OP_STEP, 8'h00, 8'h00, 3'h0, 11'h000);
      check_value({5'h00, program_counter}, {5'h00, w[10:0] + 11'h001});
    end
    $display("[TEST] counter done");
    // Table read splits the fetched word between lookup byte and result.
    for (int i = 0; i < 6; i++) begin
      w = 16'($random(seed));
      rom_data = w;
      do_op(OP_TABLE_READ_OP, 8'h00, 8'h00, 3'h0, 11'h000);
      check_value({7'h00, we, res}, {8'h01, w[7:0]});
      reg_rd(ADDR_LOOKUP);
      check_value({8'h00, rd}, {8'h00, w[15:8]});
    end
    // A reset in mid-run brings the counter back to zero at the next clock edge.
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    check_value({5'h00, program_counter}, 16'h0000);
    $display("[TEST] table done");
    print_verdict();
  end
endmodule
